// ===== dv/test_tx_power_alarm_loopback_control.sv
`timescale 1ns/100ps
module test_tx_power_alarm_loopback_control;
    localparam logic [15:0] TGT = 16'h0004;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic clkEn = 1'b1;
    logic comparatorBelow = 1'b0;
    logic [2:0] regAddr;
    logic [31:0] regWrData, regRdData, rdVal;
    logic regWrEn, regRdEn, belowThresholdFlag, powerAlarmN, loopbackSwitchClosed;
    logic loopbackAtten20dB, txAmpPowerOff, rxLnaPowerOff, rxIf1PowerOff, rxIf2PowerOff;
    logic transmitterPowerdown, rxFilterBypass, txOffsetDacEnable;
    logic [6:0] rampdownFadeUs, rxFilterCutoffCode;
    logic [5:0] rxBasebandGainDb, txQOffsetCode;
    logic signed [5:0] txIOffset, txQOffset;
    logic [31:0] rstVal [8] = '{32'h0, 32'h20, 32'h0, 32'h4100_0000, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] maskVal [4] = '{32'h0, 32'h001c_0020, 32'h00ff_f800, 32'hfff8_0600};
    logic [31:0] fade [4] = '{32'h1c, 32'h2a, 32'h39, 32'h4b};
    int nErrors = 0;
    int compares = 0;
    logic [31:0] n;

    tpal_top #(.DWELL_TARGET(TGT)) i_tpal_top (.sys_clk, .nrst, .clkEn, .regAddr, .regWrData,
        .regWrEn, .regRdEn, .regRdData, .comparatorBelow, .belowThresholdFlag, .powerAlarmN,
        .loopbackSwitchClosed, .loopbackAtten20dB, .txAmpPowerOff, .rxLnaPowerOff,
        .rxIf1PowerOff, .rxIf2PowerOff, .transmitterPowerdown, .rampdownTimeSelect(),
        .rampdownFadeUs, .rxFilterCutoffCode, .rxFilterBypass, .rxBasebandGainCode(),
        .rxBasebandGainDb, .txBiasEnable(), .txOffsetDacEnable, .txIOffsetCode(),
        .txQOffsetCode, .txIOffset, .txQOffset);
    tpal_host_model i_tpal_host_model (.sys_clk, .regRdData, .regAddr, .regWrData,
        .regWrEn, .regRdEn);

    always #4 sys_clk = ~sys_clk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            nErrors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stopTest();
        if (nErrors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic waitFlag(input logic v);
        for (int i = 0; i < 20 && belowThresholdFlag !== v; i++)
        begin
            @(posedge sys_clk);
            #1;
        end
    endtask

    initial
    begin
        #(8 * 3000);
        nErrors++;
        stopTest();
    end

    initial
    begin
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
        chk("alarm", 32'h1, powerAlarmN);
        chk("fade", 32'h1c, rampdownFadeUs);
        chk("txpd", 32'h1, transmitterPowerdown);
        for (int a = 0; a < 8; a++)
        begin
            i_tpal_host_model.rd(3'(a), rdVal);
            chk("reset value", rstVal[a], rdVal);
        end
        for (int a = 0; a < 4; a++)
        begin
            i_tpal_host_model.wr(3'(a), 32'hffff_ffff);
            i_tpal_host_model.rd(3'(a), rdVal);
            chk("writable bits", maskVal[a], rdVal);
        end
        chk("loop", 32'h1, loopbackSwitchClosed);
        chk("atten", 32'h1, loopbackAtten20dB);
        chk("pwroff", 32'hf, {txAmpPowerOff, rxLnaPowerOff, rxIf1PowerOff, rxIf2PowerOff});
        chk("cutoff", 32'h7f, rxFilterCutoffCode);
        chk("bypass", 32'h1, rxFilterBypass);
        chk("dac", 32'h1, txOffsetDacEnable);
        chk("ioff", 32'h1f, {26'h0, txIOffset});
        i_tpal_host_model.wr(3'h1, 32'h0000_0000);
        chk("pwroff", 32'h0, {txAmpPowerOff, rxLnaPowerOff, rxIf1PowerOff, rxIf2PowerOff});
        chk("loop", 32'h0, loopbackSwitchClosed);
        for (int c = 0; c < 4; c++)
        begin
            i_tpal_host_model.wr(3'h3, 32'(c) << 9);
            chk("fade", fade[c], rampdownFadeUs);
        end
        chk("dac", 32'h0, txOffsetDacEnable);
        i_tpal_host_model.wr(3'h3, 32'hc108_0000);
        chk("ioff", 32'h0, {26'h0, txIOffset});
        chk("qoff", 32'h1, {26'h0, txQOffset});
        chk("qcode", 32'h21, {26'h0, txQOffsetCode});
        i_tpal_host_model.wr(3'h2, 32'h0000_0800);
        chk("gain", 32'h0a, rxBasebandGainDb);
        i_tpal_host_model.calStep(7'h37);
        i_tpal_host_model.calStep(7'h39);
        i_tpal_host_model.calStep(7'h38);
        chk("gain", 32'h16, rxBasebandGainDb);
        chk("cutoff", 32'h38, rxFilterCutoffCode);
        i_tpal_host_model.monitorSetup();
        chk("atten", 32'h1, loopbackAtten20dB);
        chk("lnaoff", 32'h1, rxLnaPowerOff);
        i_tpal_host_model.armAfterTxOn();
        chk("txoff", 32'h0, txAmpPowerOff);
        // Two short dips must not add up to a full dwell
        for (int b = 0; b < 2; b++)
        begin
            comparatorBelow <= 1'b1;
            waitFlag(1'b1);
            comparatorBelow <= 1'b0;
            waitFlag(1'b0);
        end
        chk("alarm", 32'h1, powerAlarmN);
        comparatorBelow <= 1'b1;
        waitFlag(1'b1);
        chk("flag", 32'h1, belowThresholdFlag);
        n = 0;
        while (powerAlarmN === 1'b1 && n < 40)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk("dwell", {16'h0, TGT}, n);
        i_tpal_host_model.rd(3'h0, rdVal);
        chk("status", 32'h3, rdVal);
        comparatorBelow <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #1;
        chk("alarm", 32'h0, powerAlarmN);
        i_tpal_host_model.wr(3'h1, 32'h0010_0000);
        repeat (3) @(posedge sys_clk);
        #1;
        chk("alarm", 32'h0, powerAlarmN);
        i_tpal_host_model.wr(3'h1, 32'h0000_0000);
        i_tpal_host_model.wr(3'h1, 32'h0010_0000);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("alarm", 32'h1, powerAlarmN);
        i_tpal_host_model.rd(3'h0, rdVal);
        chk("status", 32'h0, rdVal);
        // A write while the clock enable is low must leave everything as it was
        clkEn <= 1'b0;
        i_tpal_host_model.wr(3'h2, 32'h0000_0000);
        clkEn <= 1'b1;
        i_tpal_host_model.rd(3'h2, rdVal);
        chk("frozen", 32'h0038_6800, rdVal);
        chk("gain", 32'h16, rxBasebandGainDb);
        stopTest();
    end
endmodule // test_tx_power_alarm_loopback_control

// ===== dv/tpal_host_model.sv
`timescale 1ns/100ps
module tpal_host_model
(
    input  wire logic        sys_clk,
    input  wire logic [31:0] regRdData,
    output logic [2:0]       regAddr,
    output logic [31:0]      regWrData,
    output logic             regWrEn,
    output logic             regRdEn
);
    initial
    begin
        regAddr = 3'h0;
        regWrData = 32'h0000_0000;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end

    // Released data lines show the inverse so stale values are never read as valid
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
        regWrData <= ~d;
        #1;
    endtask

    task automatic rd(input logic [2:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        #1;
        d = regRdData;
    endtask

    task automatic monitorSetup();
        wr(3'h1, 32'h0008_0000);
        wr(3'h1, 32'h000c_0000);
    endtask

    // One calibration step: new cutoff code, baseband gain kept at 22 dB
    task automatic calStep(input logic [6:0] code);
        wr(3'h2, {9'h000, code, 5'h0d, 11'h000});
    endtask

    task automatic armAfterTxOn();
        wr(3'h1, 32'h0000_0000);
        wr(3'h1, 32'h0010_0000);
    endtask
endmodule // tpal_host_model

// ===== dv/tpal_top_asserts.sv
`timescale 1ns/100ps
module tpal_checker
#(
    parameter logic [15:0] DWELL_TARGET = 16'h0400
)
(
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              clkEn,
    input  wire logic [2:0]        regAddr,
    input  wire logic [31:0]       regWrData,
    input  wire logic              regWrEn,
    input  wire logic              comparatorBelow,
    input  wire logic              belowThresholdFlag,
    input  wire logic              powerAlarmN,
    input  wire logic              loopbackSwitchClosed,
    input  wire logic              loopbackAtten20dB,
    input  wire logic              txAmpPowerOff,
    input  wire logic              rxLnaPowerOff,
    input  wire logic              rxIf1PowerOff,
    input  wire logic              rxIf2PowerOff,
    input  wire logic              transmitterPowerdown,
    input  wire logic [1:0]        rampdownTimeSelect,
    input  wire logic [6:0]        rampdownFadeUs,
    input  wire logic [6:0]        rxFilterCutoffCode,
    input  wire logic              rxFilterBypass,
    input  wire logic [4:0]        rxBasebandGainCode,
    input  wire logic              txBiasEnable,
    input  wire logic              txOffsetDacEnable,
    input  wire logic [5:0]        txIOffsetCode,
    input  wire logic signed [5:0] txIOffset
);
    logic        armBit;
    logic [1:0]  upCnt;
    logic [15:0] runCnt;
    logic [31:0] prevData;
    logic        rearmHit;

    // Rising edge of the stored re-arm bit
    assign rearmHit = clkEn && regWrEn && regAddr == 3'h1 && regWrData[20] && !armBit;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            armBit <= 1'b0;
            upCnt <= 2'h0;
            runCnt <= 16'h0000;
            prevData <= 32'h0000_0000;
        end
        else
        begin
            prevData <= regWrData;
            if (clkEn && regWrEn && regAddr == 3'h1)
                armBit <= regWrData[20];
            if (clkEn && upCnt != 2'h3)
                upCnt <= upCnt + 2'h1;
            // Consecutive flag-high edges, independent of the alarm
            if (clkEn)
                runCnt <= !belowThresholdFlag ? 16'h0000 :
                          (runCnt == 16'hffff) ? runCnt : runCnt + 16'h0001;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    flag_follow_a: assert property (upCnt == 2'h3 && $past(clkEn) && $past(clkEn, 2)
        |-> belowThresholdFlag == $past(comparatorBelow, 2)) else $error("flag lag wrong");
    alarm_fall_a: assert property ($fell(powerAlarmN) |-> runCnt >= DWELL_TARGET)
        else $error("alarm set early");
    alarm_rise_a: assert property ($rose(powerAlarmN) |-> $past(rearmHit, 2))
        else $error("alarm cleared without re-arm");
    rearm_clear_a: assert property ((rearmHit && !belowThresholdFlag ##1 clkEn[*2])
        |=> powerAlarmN) else $error("re-arm ignored");
    reg1_decode_a: assert property (clkEn && regWrEn && regAddr == 3'h1
        |=> loopbackSwitchClosed == prevData[18] && loopbackAtten20dB == prevData[19])
        else $error("loopback decode wrong");
    lb_power_a: assert property (rxLnaPowerOff == loopbackSwitchClosed
        && rxIf1PowerOff == loopbackSwitchClosed && rxIf2PowerOff == loopbackSwitchClosed
        && txAmpPowerOff == (loopbackSwitchClosed || transmitterPowerdown))
        else $error("loopback power-off wrong");
    ramp_decode_a: assert property (rampdownFadeUs == (rampdownTimeSelect == 2'h0 ? 7'h1c :
        rampdownTimeSelect == 2'h1 ? 7'h2a : rampdownTimeSelect == 2'h2 ? 7'h39 : 7'h4b))
        else $error("fade decode wrong");
    reg2_decode_a: assert property (clkEn && regWrEn && regAddr == 3'h2
        |=> rxFilterCutoffCode == prevData[22:16] && rxFilterBypass == prevData[23]
        && rxBasebandGainCode == prevData[15:11]) else $error("rx decode wrong");
    offset_mid_a: assert property (txOffsetDacEnable == txBiasEnable
        && (!txBiasEnable || txIOffsetCode != 6'h20 || txIOffset == 6'h00))
        else $error("offset decode wrong");

    cover property ($fell(powerAlarmN));
    cover property ($rose(powerAlarmN));
    cover property (loopbackSwitchClosed && loopbackAtten20dB);
endmodule // tpal_checker

bind tpal_top tpal_checker #(.DWELL_TARGET(DWELL_TARGET)) i_tpal_checker (
    .sys_clk, .nrst, .clkEn, .regAddr, .regWrData, .regWrEn, .comparatorBelow,
    .belowThresholdFlag, .powerAlarmN, .loopbackSwitchClosed, .loopbackAtten20dB,
    .txAmpPowerOff, .rxLnaPowerOff, .rxIf1PowerOff, .rxIf2PowerOff, .transmitterPowerdown,
    .rampdownTimeSelect, .rampdownFadeUs, .rxFilterCutoffCode, .rxFilterBypass,
    .rxBasebandGainCode, .txBiasEnable, .txOffsetDacEnable, .txIOffsetCode, .txIOffset
);

// ===== src/tpal_dwell.sv
`timescale 1ns/100ps
module tpal_dwell
#(
    parameter int          CNT_W  = 16,
    parameter logic [15:0] TARGET = tpal_pkg::DWELL_TARGET_DEF
)
(
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    input  wire logic             clkEn,
    input  wire logic             belowFlag,
    input  wire logic             rearm,
    output logic                  powerAlarmN,
    output logic [CNT_W-1:0]      dwellCount
);

    typedef struct packed
    {
        logic [CNT_W-1:0] count;
        logic             alarmN;
    } tpal_dwell_t;

    localparam logic [CNT_W-1:0] TGT_M1 = CNT_W'(TARGET - 16'h0001);

    tpal_dwell_t st;
    tpal_dwell_t next_st;
    logic        hit;

    always_comb
    begin
        next_st = st;
        hit     = belowFlag && st.alarmN && (st.count == TGT_M1);
        if (!belowFlag)
        begin
            next_st.count = '0; // RQ3
        end
        else if (st.alarmN)
        begin
            next_st.count = st.count + CNT_W'(1); // RQ2
        end
        if (hit)
        begin
            next_st.alarmN = 1'b0; // RQ4
        end
        else if (rearm)
        begin
            // Alarm set in the same cycle wins over re-arm
            next_st.alarmN = 1'b1; // RQ5
            next_st.count  = '0;
        end
    end

    // Runs on the reference-derived system clock
    always_ff @(posedge sys_clk or negedge nrst) // RQ20
    begin
        if (!nrst)
        begin
            st <= '{count: '0, alarmN: 1'b1};
        end
        else if (clkEn)
        begin
            st <= next_st;
        end
    end

    assign powerAlarmN = st.alarmN;
    assign dwellCount  = st.count;

endmodule // tpal_dwell

// ===== src/tpal_pkg.sv
// What this block does
// RQ1: Flag goes high when level is below threshold.
// RQ2: Dwell counter runs while flag and alarm high.
// RQ3: Dwell counter clears when flag is low.
// RQ4: Target count with flag high drives alarm low.
// RQ5: Alarm stays low until software re-arm.
// RQ6: Only rising re-arm bit resets alarm logic.
// RQ7: Ramp select codes give 28/42/57/75 us fades.
// RQ8: Loopback enable bit closes loopback switch.
// RQ9: Loopback powers off TX amp, LNA, IF1, IF2.
// RQ10: Attenuation bit selects 20 dB or minimum loss.
// RQ11: Seven-bit cutoff code, all-ones lowest corner.
// RQ12: Bias bit enables TX bias and offset DAC.
// RQ13: Six-bit I/Q offset codes, 100000 means zero.
// RQ14: Gain code 00001 is 10 dB, 01101 22 dB.
// RQ15: Bypass bit bypasses RX baseband filter.
// RQ16: Host sets attenuation before loopback for monitoring.
// RQ17: Host steps cutoff code to straddle 3 dB.
// RQ18: Loopback feeds modulator output to third IF amplifier.
// RQ19: Host writes re-arm again after enabling TX.
// RQ20: Dwell target is a parameter, reference clocked.
package tpal_pkg;

    // Register indices on the plain register port
    localparam logic [2:0]  ADDR_STATUS = 3'h0;
    localparam logic [2:0]  ADDR_REG1   = 3'h1;
    localparam logic [2:0]  ADDR_REG2   = 3'h2;
    localparam logic [2:0]  ADDR_REG3   = 3'h3;

    // Field positions
    localparam int TXPD_BIT   = 5;
    localparam int LB_EN_BIT  = 18;
    localparam int LB_ATT_BIT = 19;
    localparam int REARM_BIT  = 20;
    localparam int GAIN_LSB   = 11;
    localparam int CUTOFF_LSB = 16;
    localparam int BYPASS_BIT = 23;
    localparam int RAMP_LSB   = 9;
    localparam int QOFF_LSB   = 19;
    localparam int IOFF_LSB   = 25;
    localparam int BIAS_BIT   = 31;
    localparam int ALERT_BIT  = 0;
    localparam int BELOW_BIT  = 1;

    localparam int GAIN_W   = 5;
    localparam int CUTOFF_W = 7;
    localparam int OFF_W    = 6;
    localparam int RAMP_W   = 2;

    // Reset values and writable bits
    localparam logic [31:0] REG1_RESET = 32'h0000_0020;
    localparam logic [31:0] REG2_RESET = 32'h0000_0000;
    localparam logic [31:0] REG3_RESET = 32'h4100_0000;
    localparam logic [31:0] REG1_MASK  = 32'h001c_0020;
    localparam logic [31:0] REG2_MASK  = 32'h00ff_f800;
    localparam logic [31:0] REG3_MASK  = 32'hfff8_0600;

    // Typical 30 dB fade times in microseconds
    localparam logic [6:0]  RAMP_US_0 = 7'h1c;
    localparam logic [6:0]  RAMP_US_1 = 7'h2a;
    localparam logic [6:0]  RAMP_US_2 = 7'h39;
    localparam logic [6:0]  RAMP_US_3 = 7'h4b;

    // Gain in dB is this base plus the code
    localparam logic [5:0]  GAIN_DB_BASE = 6'h09;

    localparam logic [15:0] DWELL_TARGET_DEF = 16'h0400;

    function automatic logic [6:0] ramp_fade_us(input logic [1:0] code);
        case (code)
            2'h0:    ramp_fade_us = RAMP_US_0;
            2'h1:    ramp_fade_us = RAMP_US_1;
            2'h2:    ramp_fade_us = RAMP_US_2;
            default: ramp_fade_us = RAMP_US_3;
        endcase
    endfunction

    function automatic logic [5:0] gain_db(input logic [4:0] code);
        gain_db = GAIN_DB_BASE + {1'b0, code};
    endfunction

    // Offset binary to two's complement: 100000 becomes zero
    function automatic logic signed [5:0] offset_signed(input logic [5:0] code);
        offset_signed = {~code[5], code[4:0]};
    endfunction

endpackage

// ===== src/tpal_sync.sv
`timescale 1ns/100ps
module tpal_sync
(
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic clkEn,
    input  wire logic asyncIn,
    output logic      syncOut
);

    typedef struct packed
    {
        logic stage1;
        logic stage2;
    } tpal_sync_t;

    tpal_sync_t st;
    tpal_sync_t next_st;

    always_comb
    begin
        next_st        = st;
        next_st.stage1 = asyncIn;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= '0;
        end
        else if (clkEn)
        begin
            st <= next_st;
        end
    end

    assign syncOut = st.stage2;

endmodule // tpal_sync

// ===== src/tpal_top.sv
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/100ps
module tpal_top
#(
    parameter int          CNT_W        = 16,
    parameter logic [15:0] DWELL_TARGET = tpal_pkg::DWELL_TARGET_DEF
)
(
    input  wire logic               sys_clk,
    input  wire logic               nrst,
    input  wire logic               clkEn,
    input  wire logic [2:0]         regAddr,
    input  wire logic [31:0]        regWrData,
    input  wire logic               regWrEn,
    input  wire logic               regRdEn,
    output logic [31:0]             regRdData,
    input  wire logic               comparatorBelow,
    output logic                    belowThresholdFlag,
    output logic                    powerAlarmN,
    output logic                    loopbackSwitchClosed,
    output logic                    loopbackAtten20dB,
    output logic                    txAmpPowerOff,
    output logic                    rxLnaPowerOff,
    output logic                    rxIf1PowerOff,
    output logic                    rxIf2PowerOff,
    output logic                    transmitterPowerdown,
    output logic [1:0]              rampdownTimeSelect,
    output logic [6:0]              rampdownFadeUs,
    output logic [6:0]              rxFilterCutoffCode,
    output logic                    rxFilterBypass,
    output logic [4:0]              rxBasebandGainCode,
    output logic [5:0]              rxBasebandGainDb,
    output logic                    txBiasEnable,
    output logic                    txOffsetDacEnable,
    output logic [5:0]              txIOffsetCode,
    output logic [5:0]              txQOffsetCode,
    output logic signed [5:0]       txIOffset,
    output logic signed [5:0]       txQOffset
);

    typedef struct packed
    {
        logic [31:0]        reg1;
        logic [31:0]        reg2;
        logic [31:0]        reg3;
        logic               rearmPulse;
        logic [31:0]        rdData;
        logic               lbClosed;
        logic               lbAtt;
        logic               txAmpOff;
        logic               lnaOff;
        logic               if1Off;
        logic               if2Off;
        logic               txPd;
        logic [1:0]         rampSel;
        logic [6:0]         rampUs;
        logic [6:0]         cutoff;
        logic               bypass;
        logic [4:0]         gainCode;
        logic [5:0]         gainDb;
        logic               bias;
        logic               dacEn;
        logic [5:0]         iCode;
        logic [5:0]         qCode;
        logic signed [5:0]  iOff;
        logic signed [5:0]  qOff;
    } tpal_top_t;

    tpal_top_t          st;
    tpal_top_t          next_st;
    logic               belowSync;
    logic               alarmN;
    logic [CNT_W-1:0]   dwellCount;
    logic [31:0]        r1;
    logic [31:0]        r2;
    logic [31:0]        r3;
    logic               lbOn;

    // Comparator output comes from the analog side, so it is synchronised
    tpal_sync u_sync
    (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .clkEn   (clkEn),
        .asyncIn (comparatorBelow), // RQ1
        .syncOut (belowSync)
    );

    tpal_dwell
    #(
        .CNT_W  (CNT_W),
        .TARGET (DWELL_TARGET)
    )
    u_dwell
    (
        .sys_clk     (sys_clk),
        .nrst        (nrst),
        .clkEn       (clkEn),
        .belowFlag   (belowSync),
        .rearm       (st.rearmPulse),
        .powerAlarmN (alarmN),
        .dwellCount  (dwellCount)
    );

    always_comb
    begin
        next_st            = st;
        next_st.rearmPulse = 1'b0;
        next_st.rdData     = '0;

        // Register writes
        if (regWrEn)
        begin
            case (regAddr)
                tpal_pkg::ADDR_REG1:
                begin
                    next_st.reg1 = regWrData & tpal_pkg::REG1_MASK;
                    // Only a 0 to 1 change of the re-arm bit counts
                    next_st.rearmPulse = regWrData[tpal_pkg::REARM_BIT]
                                       && !st.reg1[tpal_pkg::REARM_BIT]; // RQ6
                end
                tpal_pkg::ADDR_REG2:
                begin
                    next_st.reg2 = regWrData & tpal_pkg::REG2_MASK;
                end
                tpal_pkg::ADDR_REG3:
                begin
                    next_st.reg3 = regWrData & tpal_pkg::REG3_MASK;
                end
                default:
                begin
                    next_st.reg1 = st.reg1;
                end
            endcase
        end

        // Register reads, data in the following cycle only
        if (regRdEn)
        begin
            case (regAddr)
                tpal_pkg::ADDR_STATUS:
                begin
                    next_st.rdData[tpal_pkg::ALERT_BIT] = !alarmN;
                    next_st.rdData[tpal_pkg::BELOW_BIT] = belowSync;
                end
                tpal_pkg::ADDR_REG1:
                begin
                    next_st.rdData = st.reg1;
                end
                tpal_pkg::ADDR_REG2:
                begin
                    next_st.rdData = st.reg2;
                end
                tpal_pkg::ADDR_REG3:
                begin
                    next_st.rdData = st.reg3;
                end
                default:
                begin
                    next_st.rdData = '0;
                end
            endcase
        end

        // Decoded controls follow the new register contents
        r1   = next_st.reg1;
        r2   = next_st.reg2;
        r3   = next_st.reg3;
        lbOn = r1[tpal_pkg::LB_EN_BIT];

        // Switch joins modulator output to the third IF amplifier input
        next_st.lbClosed = lbOn; // RQ8 RQ18
        next_st.lbAtt    = r1[tpal_pkg::LB_ATT_BIT]; // RQ10
        next_st.txPd     = r1[tpal_pkg::TXPD_BIT];
        next_st.txAmpOff = lbOn || r1[tpal_pkg::TXPD_BIT]; // RQ9
        next_st.lnaOff   = lbOn; // RQ9
        next_st.if1Off   = lbOn; // RQ9
        next_st.if2Off   = lbOn; // RQ9

        next_st.rampSel  = r3[tpal_pkg::RAMP_LSB +: tpal_pkg::RAMP_W];
        next_st.rampUs   = tpal_pkg::ramp_fade_us(
                               r3[tpal_pkg::RAMP_LSB +: tpal_pkg::RAMP_W]); // RQ7

        // Larger code gives a lower corner, all ones the lowest
        next_st.cutoff   = r2[tpal_pkg::CUTOFF_LSB +: tpal_pkg::CUTOFF_W]; // RQ11
        next_st.bypass   = r2[tpal_pkg::BYPASS_BIT]; // RQ15
        next_st.gainCode = r2[tpal_pkg::GAIN_LSB +: tpal_pkg::GAIN_W];
        next_st.gainDb   = tpal_pkg::gain_db(
                               r2[tpal_pkg::GAIN_LSB +: tpal_pkg::GAIN_W]); // RQ14

        next_st.bias     = r3[tpal_pkg::BIAS_BIT]; // RQ12
        next_st.dacEn    = r3[tpal_pkg::BIAS_BIT]; // RQ12
        next_st.iCode    = r3[tpal_pkg::IOFF_LSB +: tpal_pkg::OFF_W];
        next_st.qCode    = r3[tpal_pkg::QOFF_LSB +: tpal_pkg::OFF_W];
        // The DAC offset is zero unless the internal bias is on
        next_st.iOff     = r3[tpal_pkg::BIAS_BIT]
                         ? tpal_pkg::offset_signed(
                               r3[tpal_pkg::IOFF_LSB +: tpal_pkg::OFF_W])
                         : 6'sh00; // RQ13
        next_st.qOff     = r3[tpal_pkg::BIAS_BIT]
                         ? tpal_pkg::offset_signed(
                               r3[tpal_pkg::QOFF_LSB +: tpal_pkg::OFF_W])
                         : 6'sh00; // RQ13
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st          <= '0;
            st.reg1     <= tpal_pkg::REG1_RESET;
            st.reg2     <= tpal_pkg::REG2_RESET;
            st.reg3     <= tpal_pkg::REG3_RESET;
            st.txPd     <= 1'b1;
            st.txAmpOff <= 1'b1;
            st.rampUs   <= tpal_pkg::RAMP_US_0;
            st.gainDb   <= tpal_pkg::GAIN_DB_BASE;
            st.iCode    <= 6'h20;
            st.qCode    <= 6'h20;
        end
        else if (clkEn)
        begin
            st <= next_st;
        end
    end

    assign regRdData            = st.rdData;
    assign belowThresholdFlag   = belowSync;
    assign powerAlarmN          = alarmN;
    assign loopbackSwitchClosed = st.lbClosed;
    assign loopbackAtten20dB    = st.lbAtt;
    assign txAmpPowerOff        = st.txAmpOff;
    assign rxLnaPowerOff        = st.lnaOff;
    assign rxIf1PowerOff        = st.if1Off;
    assign rxIf2PowerOff        = st.if2Off;
    assign transmitterPowerdown = st.txPd;
    assign rampdownTimeSelect   = st.rampSel;
    assign rampdownFadeUs       = st.rampUs;
    assign rxFilterCutoffCode   = st.cutoff;
    assign rxFilterBypass       = st.bypass;
    assign rxBasebandGainCode   = st.gainCode;
    assign rxBasebandGainDb     = st.gainDb;
    assign txBiasEnable         = st.bias;
    assign txOffsetDacEnable    = st.dacEn;
    assign txIOffsetCode        = st.iCode;
    assign txQOffsetCode        = st.qCode;
    assign txIOffset            = st.iOff;
    assign txQOffset            = st.qOff;

endmodule // tpal_top
